// ---- bench/core_exec_assertions.sv ----
`timescale 1ns/100ps
module core_exec_assertions (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // fetch and stack
    input wire logic [13:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic o_instr_ready,
    input wire logic [14:0] i_stack_top,
    input wire logic o_stack_pop,
    // core status
    input wire logic [14:0] o_program_counter,
    input wire logic o_global_irq_enable,
    input wire logic o_soft_reset
);
    import core_exec_pkg::*;
    logic take;
    assign take = i_instr_valid && o_instr_ready;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_pop_on_iret: assert property (take && i_instr == 14'h0009 |-> o_stack_pop)
        else $error("no stack pop on interrupt return");
    a_pop_cause: assert property (o_stack_pop |-> take && i_instr == 14'h0009)
        else $error("stray stack pop");
    a_pc_from_stack: assert property (o_stack_pop |=> o_program_counter == $past(i_stack_top))
        else $error("pc not loaded from stack top");
    a_gie_set: assert property (o_stack_pop |=> o_global_irq_enable)
        else $error("interrupt enable not set");
    a_ready_gap: assert property (o_stack_pop |=> !o_instr_ready ##1 o_instr_ready)
        else $error("interrupt return not two cycles");
    a_nop_step: assert property (take && i_instr == 14'h0000 |=>
        o_program_counter == $past(o_program_counter) + 15'h0001)
        else $error("no-op did not step pc");
    a_lit_step: assert property (take && i_instr[13:8] == 6'h30 |=>
        o_program_counter == $past(o_program_counter) + 15'h0001)
        else $error("literal load not one cycle");
    a_swrst_pulse: assert property (take && i_instr == 14'h0001 |=>
        o_soft_reset ##1 !o_soft_reset)
        else $error("software reset pulse wrong");
    a_swrst_state: assert property (o_soft_reset |-> o_program_counter == 15'h0000
        && !o_global_irq_enable)
        else $error("software reset left state");
    cover property (o_stack_pop);
    cover property (o_soft_reset);
    cover property (take && i_instr[13:7] == 7'h7f);
endmodule : core_exec_assertions

bind core_exec core_exec_assertions u_chk (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_instr(i_instr),
    .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready),
    .i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop),
    .o_program_counter(o_program_counter),
    .o_global_irq_enable(o_global_irq_enable), .o_soft_reset(o_soft_reset)
);

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb;
    import core_exec_pkg::*;
    typedef struct packed {
        logic [13:0] ins;
        logic [11:0] a;
        logic [31:0] e;
    } row_t;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic i_instr_valid = 1'b0;
    logic [14:0] i_stack_top = 15'h0000;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wr_data = 32'h0;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic o_instr_ready, o_stack_pop, o_global_irq_enable, o_soft_reset;
    logic [14:0] o_program_counter;
    logic [31:0] o_rd_data;
    int error_cnt = 0;
    int comparisons = 0;
    // instruction, then a bus read and its expected value
    row_t rows [24] = '{
        '{14'h006a, 12'h004, 32'h2a},
        '{14'h31ff, 12'h008, 32'h7f},
        '{14'h30a5, 12'h000, 32'ha5},
        '{14'h00d0, 12'h540, 32'ha5},
        '{14'h0019, 12'h00c, 32'hffff},
        '{14'h0000, 12'h7fc, 32'ha5},
        '{14'h0018, 12'h00c, 32'h0},
        '{14'h0000, 12'h400, 32'ha5},
        '{14'h301e, 12'h000, 32'h1e},
        '{14'h001e, 12'h010, 32'h1},
        '{14'h0000, 12'h400, 32'h1e},
        '{14'h001f, 12'h010, 32'h0},
        '{14'h0000, 12'h404, 32'h1e},
        '{14'h3fe1, 12'h010, 32'h0},
        '{14'h0000, 12'h784, 32'h1e},
        '{14'h3f9f, 12'h00c, 32'h0},
        '{14'h0000, 12'h47c, 32'h1e},
        '{14'h3077, 12'h000, 32'h77},
        '{14'h0081, 12'h400, 32'h77},
        '{14'h0041, 12'h004, 32'h01},
        '{14'h00c5, 12'h714, 32'h77},
        '{14'h3003, 12'h000, 32'h03},
        '{14'h0080, 12'h400, 32'h03},
        '{14'h0000, 12'h020, 32'h5a}
    };

    core_exec dut (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_instr(i_instr),
        .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready),
        .i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop),
        .o_program_counter(o_program_counter), .o_global_irq_enable(o_global_irq_enable),
        .o_soft_reset(o_soft_reset), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data)
    );

    initial begin
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
        comparisons++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask : chk

    task automatic ex(input logic [13:0] ins);
        @(posedge i_ref_clk);
        i_instr <= ins;
        i_instr_valid <= 1'b1;
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b0;
    endtask : ex

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd_en <= 1'b1;
        @(posedge i_ref_clk);
        i_rd_en <= 1'b0;
        #1;
        chk(o_rd_data, e, n);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_en <= 1'b1;
        @(posedge i_ref_clk);
        i_wr_en <= 1'b0;
    endtask : wr

    task automatic test_done;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd(12'h01c, 32'h04, "supply");
        rd(12'h0fc, 32'h0, "unmapped");
        chk(o_instr_ready, 1'b1, "ready");
        // status is software-only, so a value set here must survive all rows
        wr(12'h020, 32'h5a);
        for (int i = 0; i < 24; i++) begin
            ex(rows[i].ins);
            rd(rows[i].a, rows[i].e, "row");
        end
        rd(12'h014, 32'h18, "pc");
        // interrupt return with the next instruction held waiting
        @(posedge i_ref_clk);
        i_instr <= 14'h0009;
        i_instr_valid <= 1'b1;
        i_stack_top <= 15'h5a5a;
        #1;
        chk(o_stack_pop, 1'b1, "pop");
        @(posedge i_ref_clk);
        i_instr <= 14'h3011;
        #1;
        chk(o_program_counter, 15'h5a5a, "pc");
        chk(o_global_irq_enable, 1'b1, "irq_enable");
        chk(o_instr_ready, 1'b0, "ready");
        // second cycle refuses the waiting instruction
        @(posedge i_ref_clk);
        #1;
        chk(o_program_counter, 15'h5a5a, "pc");
        chk(o_instr_ready, 1'b1, "ready");
        @(posedge i_ref_clk);
        i_instr_valid <= 1'b0;
        #1;
        chk(o_program_counter, 15'h5a5b, "pc");
        rd(12'h018, 32'h80, "intctl");
        rd(12'h000, 32'h11, "acc");
        wr(12'h00c, 32'h1111);
        ex(14'h0001);
        #1;
        chk(o_soft_reset, 1'b1, "swrst");
        @(posedge i_ref_clk);
        #1;
        chk(o_soft_reset, 1'b0, "swrst");
        rd(12'h00c, 32'h0, "ptr0");
        rd(12'h01c, 32'h0, "supply");
        rd(12'h018, 32'h0, "intctl");
        // hardware reset in mid-run: registers take their reset values, memory keeps its cells
        ex(14'h3055);
        @(posedge i_ref_clk);
        i_rst_n <= 1'b0;
        @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd(12'h000, 32'h0, "acc");
        rd(12'h01c, 32'h04, "supply");
        rd(12'h400, 32'h03, "cell");
        test_done();
    end

    initial begin
        repeat (5000) @(posedge i_ref_clk);
        error_cnt++;
        test_done();
    end
endmodule : tb

// ---- verilog/core_exec.sv ----
// Contract
// RL1: the bank-literal load puts its 6-bit operand in the bank select register, flags untouched.
// RL2: the page-latch literal load puts its 7-bit operand in the upper pc latch, flags untouched.
// RL3: the accumulator literal load copies its 8-bit operand to the accumulator in one cycle.
// RL4: the store-to-file writes the accumulator to the file address in the 7-bit operand.
// RL5: the indirect store mode field is 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// RL6: the offset form addresses the pointer plus a signed offset from -32 to 31.
// RL7: afterwards the pointer is plus one, minus one, or unchanged for the offset form.
// RL8: an access to an indirect alias goes to the address held in its pointer.
// RL9: pointers are 16 bits and wrap both ways.
// RL10: the pointer update and the indirect store change no status flag.
// RL11: the software reset resets the core and clears the reset-instruction flag.
// RL12: interrupt return pops the stack into the pc and takes two cycles.
// RL13: interrupt return sets the global interrupt enable, bit 7 of interrupt control.
// RL14: the no-op takes one cycle and only advances the pc.
// RL15: the indirect store picks one of two pointers by a one-bit index.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "core_exec_map.svh"
module core_exec (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // instruction fetch side
    input wire logic [13:0] i_instr,
    input wire logic i_instr_valid,
    output logic o_instr_ready,
    // hardware stack
    input wire logic [14:0] i_stack_top,
    output logic o_stack_pop,
    // core status
    output logic [14:0] o_program_counter,
    output logic o_global_irq_enable,
    output logic o_soft_reset,
    // register bus
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [31:0] o_rd_data
);
    import core_exec_pkg::*;

    localparam core_exec_pkg::core_state_t RST_VAL = '{
        state: ST_EXEC,
        acc: `ACC_RST,
        bank_select_reg: `BANK_RST,
        prog_counter_high_latch: `PAGE_LATCH_RST,
        ptr0: `PTR_RST,
        ptr1: `PTR_RST,
        program_counter: `PC_RST,
        interrupt_control_reg: `INTCTL_RST,
        supply_control_reg: `SUPPLY_RST,
        status: `STATUS_RST,
        rdata: 32'h0000_0000,
        mem_rd: 1'b0,
        soft_rst: 1'b0
    };

    core_state_t s;
    core_state_t next_s;

    data_mem_if mif ();

    data_mem u_mem (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .port(mif.mem)
    );

    // operand fields
    logic take;
    logic sel;
    logic use_offset;
    logic [1:0] mode;
    logic [5:0] offset;
    logic [6:0] file_addr;
    logic is_stim;
    logic is_stik;
    logic bus_mem;
    logic [15:0] ea0;
    logic [15:0] ea1;
    logic [15:0] np0;
    logic [15:0] np1;
    logic core_we;
    logic [7:0] core_waddr;
    logic [7:0] file_waddr;
    logic [15:0] store_ea;
    logic [31:0] reg_rd;
    // decoded instruction classes
    logic is_nop;
    logic is_swrst;
    logic is_iret;
    logic is_bank;
    logic is_page;
    logic is_litw;
    logic is_stf;
    logic is_store;

    assign take = i_instr_valid && (s.state == ST_EXEC);
    assign is_stim = (i_instr & `MSK_STIM) == `OP_STIM;
    assign is_stik = (i_instr & `MSK_STIK) == `OP_STIK;
    assign use_offset = is_stik;
    assign mode = i_instr[1:0];
    assign offset = i_instr[5:0];
    assign file_addr = i_instr[6:0];
    // pointer index sits in bit 2 of the mode form, bit 6 of the offset form
    assign sel = is_stik ? i_instr[6] : i_instr[2]; // RL15
    assign bus_mem = i_addr[11:10] == `MEM_WIN;

    // instruction classes
    assign is_nop = i_instr == `OP_NOP;
    assign is_swrst = i_instr == `OP_SWRST;
    assign is_iret = i_instr == `OP_IRET;
    assign is_bank = (i_instr & `MSK_BANK) == `OP_BANK;
    assign is_page = (i_instr & `MSK_PAGE) == `OP_PAGE;
    assign is_litw = (i_instr & `MSK_LITW) == `OP_LITW;
    assign is_stf = (i_instr & `MSK_STF) == `OP_STF;
    assign is_store = is_stim || is_stik;
    assign store_ea = sel ? ea1 : ea0; // RL15

    ptr_update #(.W(16)) u_ptr0 (
        .i_ptr(s.ptr0),
        .i_mode(mode),
        .i_use_offset(use_offset),
        .i_offset(offset),
        .o_ea(ea0),
        .o_next_ptr(np0)
    );

    ptr_update #(.W(16)) u_ptr1 (
        .i_ptr(s.ptr1),
        .i_mode(mode),
        .i_use_offset(use_offset),
        .i_offset(offset),
        .o_ea(ea1),
        .o_next_ptr(np1)
    );

    // store-to-file target, an alias redirects through its pointer
    always_comb begin
        case (file_addr)
            `ALIAS0: file_waddr = s.ptr0[7:0]; // RL8
            `ALIAS1: file_waddr = s.ptr1[7:0]; // RL8
            default: file_waddr = {s.bank_select_reg[0], file_addr};
        endcase
    end

    // data memory port: core stores win over bus writes
    always_comb begin
        core_we = 1'b0;
        core_waddr = 8'h00;
        if (take && is_store) begin
            core_we = 1'b1;
            core_waddr = store_ea[7:0];
        end else if (take && is_stf) begin // RL4
            core_we = 1'b1;
            core_waddr = file_waddr;
        end
    end

    assign mif.we = core_we || (i_wr_en && bus_mem);
    assign mif.waddr = core_we ? core_waddr : i_addr[9:2];
    assign mif.wdata = core_we ? s.acc : i_wr_data[7:0];
    assign mif.raddr = i_addr[9:2];

    // register read mux, registered for the cycle after the strobe
    always_comb begin
        reg_rd = 32'h0000_0000;
        case (i_addr)
            `OFS_ACC: begin
                reg_rd = {24'h00_0000, s.acc};
            end
            `OFS_BANK: begin
                reg_rd = {26'h00_0000, s.bank_select_reg};
            end
            `OFS_PAGE_LATCH: begin
                reg_rd = {25'h00_0000, s.prog_counter_high_latch};
            end
            `OFS_PTR0: begin
                reg_rd = {16'h0000, s.ptr0};
            end
            `OFS_PTR1: begin
                reg_rd = {16'h0000, s.ptr1};
            end
            `OFS_PC: begin
                reg_rd = {17'h0000, s.program_counter};
            end
            `OFS_INTCTL: begin
                reg_rd = {24'h00_0000, s.interrupt_control_reg};
            end
            `OFS_SUPPLY: begin
                reg_rd = {24'h00_0000, s.supply_control_reg};
            end
            `OFS_STATUS: begin
                reg_rd = {24'h00_0000, s.status};
            end
            `OFS_STATE: begin
                reg_rd = {31'h000_0000, s.state};
            end
            default: begin
                reg_rd = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.soft_rst = 1'b0;
        next_s.mem_rd = i_rd_en && bus_mem;
        next_s.rdata = 32'h0000_0000;

        // bus read, answered the next cycle
        if (i_rd_en && !bus_mem) begin
            next_s.rdata = reg_rd;
        end

        // bus write, overridden below by an instruction in the same cycle
        if (i_wr_en && !bus_mem) begin
            case (i_addr)
                `OFS_ACC: begin
                    next_s.acc = i_wr_data[7:0];
                end
                `OFS_BANK: begin
                    next_s.bank_select_reg = i_wr_data[5:0];
                end
                `OFS_PAGE_LATCH: begin
                    next_s.prog_counter_high_latch = i_wr_data[6:0];
                end
                `OFS_PTR0: begin
                    next_s.ptr0 = i_wr_data[15:0];
                end
                `OFS_PTR1: begin
                    next_s.ptr1 = i_wr_data[15:0];
                end
                `OFS_PC: begin
                    next_s.program_counter = i_wr_data[14:0];
                end
                `OFS_INTCTL: begin
                    next_s.interrupt_control_reg = i_wr_data[7:0];
                end
                `OFS_SUPPLY: begin
                    next_s.supply_control_reg = i_wr_data[7:0];
                end
                `OFS_STATUS: begin
                    next_s.status = i_wr_data[7:0];
                end
                default: begin
                    next_s.status = next_s.status;
                end
            endcase
        end

        case (s.state)
            ST_RET2: begin
                // second cycle of the interrupt return
                next_s.state = ST_EXEC; // RL12
            end
            ST_EXEC: begin
                if (take) begin
                    // apart from the software reset, which clears it, no instruction here changes the status register
                    next_s.program_counter = 15'(s.program_counter + `PC_STEP); // RL14
                    if (is_swrst) begin
                        next_s = RST_VAL; // RL11
                        next_s.supply_control_reg = s.supply_control_reg;
                        next_s.supply_control_reg[`RST_INSTR_BIT] = 1'b0; // RL11
                        next_s.soft_rst = 1'b1; // RL11
                    end else if (is_iret) begin
                        next_s.program_counter = i_stack_top; // RL12
                        next_s.interrupt_control_reg[`IRQ_EN_BIT] = 1'b1; // RL13
                        next_s.state = ST_RET2; // RL12
                    end else if (is_nop) begin
                        // nothing beyond the pc step
                        next_s.state = ST_EXEC; // RL14
                    end else if (is_bank) begin
                        next_s.bank_select_reg = i_instr[5:0]; // RL1
                    end else if (is_page) begin
                        next_s.prog_counter_high_latch = i_instr[6:0]; // RL2
                    end else if (is_litw) begin
                        next_s.acc = i_instr[7:0]; // RL3
                    end else if (is_store) begin
                        if (sel) begin
                            next_s.ptr1 = np1; // RL7
                        end else begin
                            next_s.ptr0 = np0; // RL7
                        end
                        next_s.status = s.status; // RL10
                    end
                end
            end
            default: next_s.state = ST_EXEC;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s <= RST_VAL;
        end else begin
            s <= next_s;
        end
    end

    assign o_instr_ready = s.state == ST_EXEC;
    assign o_stack_pop = take && is_iret; // RL12
    assign o_program_counter = s.program_counter;
    assign o_global_irq_enable = s.interrupt_control_reg[`IRQ_EN_BIT];
    assign o_soft_reset = s.soft_rst;
    assign o_rd_data = s.mem_rd ? {24'h00_0000, mif.rdata} : s.rdata;
endmodule : core_exec

// ---- verilog/core_exec_map.svh ----
`ifndef CORE_EXEC_MAP_SVH
`define CORE_EXEC_MAP_SVH

// register bus byte offsets
`define OFS_ACC 12'h000
`define OFS_BANK 12'h004
`define OFS_PAGE_LATCH 12'h008
`define OFS_PTR0 12'h00c
`define OFS_PTR1 12'h010
`define OFS_PC 12'h014
`define OFS_INTCTL 12'h018
`define OFS_SUPPLY 12'h01c
`define OFS_STATUS 12'h020
`define OFS_STATE 12'h024
// data memory window: addr[11:10] == 01, cell index addr[9:2]
`define MEM_WIN 2'b01

// field positions and reset values
`define IRQ_EN_BIT 7
`define RST_INSTR_BIT 2
`define ACC_RST 8'h00
`define BANK_RST 6'h00
`define PAGE_LATCH_RST 7'h00
`define PTR_RST 16'h0000
`define PC_RST 15'h0000
`define INTCTL_RST 8'h00
`define SUPPLY_RST 8'h04
`define STATUS_RST 8'h00
`define PC_STEP 15'h0001
`define PTR_STEP 16'h0001

// instruction encodings: match value and mask
`define OP_NOP 14'h0000
`define OP_SWRST 14'h0001
`define OP_IRET 14'h0009
`define OP_BANK 14'h0040
`define MSK_BANK 14'h3fc0
`define OP_PAGE 14'h3180
`define MSK_PAGE 14'h3f80
`define OP_LITW 14'h3000
`define MSK_LITW 14'h3f00
`define OP_STF 14'h0080
`define MSK_STF 14'h3f80
`define OP_STIM 14'h0018
`define MSK_STIM 14'h3ff8
`define OP_STIK 14'h3f80
`define MSK_STIK 14'h3f80
// file addresses of the two indirect aliases
`define ALIAS0 7'h00
`define ALIAS1 7'h01

`endif

// ---- verilog/core_exec_pkg.sv ----
package core_exec_pkg;

    typedef enum logic [0:0] {
        ST_EXEC = 1'b0,
        ST_RET2 = 1'b1
    } exec_state_t;

    typedef enum logic [1:0] {
        PM_PRE_INC = 2'b00,
        PM_PRE_DEC = 2'b01,
        PM_POST_INC = 2'b10,
        PM_POST_DEC = 2'b11
    } ptr_mode_t;

    typedef struct packed {
        exec_state_t state;
        logic [7:0] acc;
        logic [5:0] bank_select_reg;
        logic [6:0] prog_counter_high_latch;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [14:0] program_counter;
        logic [7:0] interrupt_control_reg;
        logic [7:0] supply_control_reg;
        logic [7:0] status;
        logic [31:0] rdata;
        logic mem_rd;
        logic soft_rst;
    } core_state_t;

endpackage : core_exec_pkg

// ---- verilog/data_mem.sv ----
`timescale 1ns/100ps
module data_mem (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // access port
    data_mem_if.mem port
);
    typedef struct packed {
        logic [255:0][7:0] cells;
        logic [7:0] rdata;
    } mem_state_t;

    mem_state_t s;
    mem_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.rdata = s.cells[port.raddr];
        if (port.we) begin
            next_s.cells[port.waddr] = port.wdata;
        end
    end

    // contents survive reset, only the read register clears
    always_ff @(posedge i_ref_clk) begin
        s.cells <= next_s.cells;
        if (!i_rst_n) begin
            s.rdata <= 8'h00;
        end else begin
            s.rdata <= next_s.rdata;
        end
    end

    assign port.rdata = s.rdata;
endmodule : data_mem

// ---- verilog/data_mem_if.sv ----
`timescale 1ns/100ps
interface data_mem_if;
    logic we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] raddr;
    logic [7:0] rdata;

    modport core (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : data_mem_if

// ---- verilog/ptr_update.sv ----
`timescale 1ns/100ps
module ptr_update #(
    parameter int W = 16
) (
    // pointer and addressing form
    input wire logic [W-1:0] i_ptr,
    input wire logic [1:0] i_mode,
    input wire logic i_use_offset,
    input wire logic [5:0] i_offset,
    // results
    output logic [W-1:0] o_ea,
    output logic [W-1:0] o_next_ptr
);
    import core_exec_pkg::*;

    logic [W-1:0] inc;
    logic [W-1:0] dec;
    logic [W-1:0] sext;

    // sums are cut to W bits so the pointer wraps
    assign inc = W'(i_ptr + W'(1)); // RL9
    assign dec = W'(i_ptr - W'(1)); // RL9
    assign sext = W'(signed'(i_offset));

    always_comb begin
        o_ea = i_ptr;
        o_next_ptr = i_ptr;
        if (i_use_offset) begin
            o_ea = W'(i_ptr + sext); // RL6
        end else begin
            case (ptr_mode_t'(i_mode)) // RL5
                PM_PRE_INC: begin
                    o_ea = inc;
                    o_next_ptr = inc; // RL7
                end
                PM_PRE_DEC: begin
                    o_ea = dec;
                    o_next_ptr = dec; // RL7
                end
                PM_POST_INC: o_next_ptr = inc; // RL7
                PM_POST_DEC: o_next_ptr = dec; // RL7
                default: o_next_ptr = i_ptr;
            endcase
        end
    end
endmodule : ptr_update
